/* File: rtl/spfp_pin_mux.sv */
// spfp_pin_mux: apb controlled function arbitration of the shared port pins
module spfp_pin_mux #(
  parameter bit HAS_PORT_B = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] port_a_in,
  output logic [5:0] port_a_out,
  output logic [5:0] port_a_oe,
  output logic [5:0] port_a_pullup,
  input wire logic [7:0] port_b_lines_in,
  output logic [7:0] port_b_lines_out,
  output logic [7:0] port_b_lines_oe,
  output logic [7:0] port_b_pullup,
  input wire logic [1:0] timer_chan_out,
  input wire logic [1:0] timer_chan_oe,
  input wire logic osc_clk,
  output logic [1:0] timer_chan_in,
  output logic timer_ext_clock_in,
  output logic ext_irq_n,
  output logic ext_reset_n,
  output logic oscillator_in_pin,
  output logic [5:0] keypad_irq_in,
  output logic [3:0] analog_chan_sel
);
  logic [spfp_pkg::FE_W-1:0] func_en;
  logic [5:0] kbi_en;
  logic [spfp_pkg::PU_W-1:0] port_a_pullup_enable_reg;
  logic [5:0] a_data;
  logic [5:0] a_dir;
  logic [7:0] b_data;
  logic [7:0] b_dir;
  logic [7:0] b_pullup;
  logic [5:0] a_meta;
  logic [5:0] a_sync;
  logic [7:0] b_meta;
  logic [7:0] b_sync;
  logic [17:0] owner_vec;
  logic oscillator_out_enable;
  logic wr_en;
  logic bad_addr;

  spfp_pin_if pin0 ();
  spfp_pin_if pin1 ();
  spfp_pin_if pin2 ();
  spfp_pin_if pin3 ();
  spfp_pin_if pin4 ();
  spfp_pin_if pin5 ();

  // decode: word aligned inside the map, port b only when fitted
  function automatic logic addr_bad(input logic [7:0] a);
    logic b;
    b = (a[1:0] != 2'h0) || (a > spfp_pkg::REG_MAX);
    if (!HAS_PORT_B && (a == spfp_pkg::REG_B_DATA ||
        a == spfp_pkg::REG_B_DIR || a == spfp_pkg::REG_B_PINS)) begin
      b = 1'b1;
    end
    return b;
  endfunction : addr_bad

  assign oscillator_out_enable =
    port_a_pullup_enable_reg[spfp_pkg::PU_OSC_OUT];
  assign bad_addr = addr_bad(paddr);
  assign wr_en = psel && penable && pwrite && !bad_addr;
  // zero wait state slave: every access completes in its access phase
  assign pready = 1'b1;
  assign pslverr = psel && penable && bad_addr;

  // function enables: all clear at reset so every pin starts as input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_en <= spfp_pkg::FUNC_EN_RST;
      kbi_en <= 6'h00;
    end else if (wr_en && paddr == spfp_pkg::REG_FUNC_EN) begin
      func_en <= pwdata[spfp_pkg::FE_W-1:0];
    end else if (wr_en && paddr == spfp_pkg::REG_KBI_EN) begin
      kbi_en <= pwdata[5:0];
    end
  end

  // pullups: six port a bits plus the oscillator-output bit, port b byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_pullup_enable_reg <= spfp_pkg::PULLUP_RST;
      b_pullup <= 8'h00;
    end else if (wr_en && paddr == spfp_pkg::REG_PULLUP) begin
      port_a_pullup_enable_reg <= {pwdata[spfp_pkg::PU_OSC_OUT], 1'b0,
                                   pwdata[5:0]};
      b_pullup <= pwdata[15:8];
    end
  end

  // port data and direction; directions reset to input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_data <= 6'h00;
      a_dir <= 6'h00;
      b_data <= 8'h00;
      b_dir <= 8'h00;
    end else if (wr_en) begin
      case (paddr)
        spfp_pkg::REG_A_DATA: a_data <= pwdata[5:0];
        spfp_pkg::REG_A_DIR: a_dir <= {pwdata[5:3], 1'b0, pwdata[1:0]};
        spfp_pkg::REG_B_DATA: b_data <= pwdata[7:0];
        spfp_pkg::REG_B_DIR: b_dir <= pwdata[7:0];
        default: a_data <= a_data;
      endcase
    end
  end

  // pin inputs come from outside the clock domain: two flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_meta <= 6'h3F;
      a_sync <= 6'h3F;
      b_meta <= 8'h00;
      b_sync <= 8'h00;
    end else begin
      a_meta <= port_a_in;
      a_sync <= a_meta;
      b_meta <= port_b_lines_in;
      b_sync <= b_meta;
    end
  end

  spfp_arbiter u_arb (
    .func_en(func_en),
    .kbi_en(kbi_en),
    .osc_out_en(oscillator_out_enable),
    .a_data(a_data),
    .a_dir(a_dir),
    .tim_out(timer_chan_out),
    .tim_oe(timer_chan_oe),
    .osc_clk(osc_clk),
    .p0(pin0.arb),
    .p1(pin1.arb),
    .p2(pin2.arb),
    .p3(pin3.arb),
    .p4(pin4.arb),
    .p5(pin5.arb)
  );

  assign owner_vec = {pin5.owner, pin4.owner, pin3.owner,
                      pin2.owner, pin1.owner, pin0.owner};

  // pad drive; the oscillator clock path is combinational on purpose
  assign port_a_oe = {pin5.drive, pin4.drive, pin3.drive,
                      pin2.drive, pin1.drive, pin0.drive};
  assign port_a_out = {pin5.value, pin4.value, pin3.value,
                       pin2.value, pin1.value, pin0.value};
  // reset pin keeps its pullup on; the pad cell adds hysteresis
  assign port_a_pullup = {port_a_pullup_enable_reg[5:4],
                          port_a_pullup_enable_reg[3] ||
                          pin3.owner == spfp_pkg::SPFP_OWN_RESET,
                          port_a_pullup_enable_reg[2:0]};
  assign port_b_lines_out = HAS_PORT_B ? b_data : 8'h00;
  assign port_b_lines_oe = HAS_PORT_B ? b_dir : 8'h00;
  assign port_b_pullup = HAS_PORT_B ? b_pullup : 8'h00;

  // routing of synchronised pins to the owning peripheral
  assign timer_chan_in[0] = pin0.owner == spfp_pkg::SPFP_OWN_TIMER
                            && a_sync[0];
  assign timer_chan_in[1] = pin1.owner == spfp_pkg::SPFP_OWN_TIMER
                            && a_sync[1];
  assign timer_ext_clock_in = pin2.owner == spfp_pkg::SPFP_OWN_TIMER
                              && a_sync[2];
  // idle high when not owned, so the sink never sees a request
  assign ext_irq_n = pin2.owner != spfp_pkg::SPFP_OWN_IRQ || a_sync[2];
  assign ext_reset_n = pin3.owner != spfp_pkg::SPFP_OWN_RESET
                       || a_sync[3];
  assign oscillator_in_pin = pin5.owner == spfp_pkg::SPFP_OWN_OSC
                             && a_sync[5];
  // keypad inputs are active low; unowned lines read idle high
  assign keypad_irq_in = {pin5.owner != spfp_pkg::SPFP_OWN_KEYPAD || a_sync[5],
                          pin4.owner != spfp_pkg::SPFP_OWN_KEYPAD || a_sync[4],
                          pin3.owner != spfp_pkg::SPFP_OWN_KEYPAD || a_sync[3],
                          pin2.owner != spfp_pkg::SPFP_OWN_KEYPAD || a_sync[2],
                          pin1.owner != spfp_pkg::SPFP_OWN_KEYPAD || a_sync[1],
                          pin0.owner != spfp_pkg::SPFP_OWN_KEYPAD
                          || a_sync[0]};
  assign analog_chan_sel = {pin5.owner == spfp_pkg::SPFP_OWN_ANALOG,
                            pin4.owner == spfp_pkg::SPFP_OWN_ANALOG,
                            pin1.owner == spfp_pkg::SPFP_OWN_ANALOG,
                            pin0.owner == spfp_pkg::SPFP_OWN_ANALOG};

  // read mux: registered so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        spfp_pkg::REG_FUNC_EN: prdata <= {22'h0, func_en};
        spfp_pkg::REG_KBI_EN: prdata <= {26'h0, kbi_en};
        spfp_pkg::REG_PULLUP: prdata <= {16'h0, b_pullup,
                                         port_a_pullup_enable_reg};
        spfp_pkg::REG_A_DATA: prdata <= {26'h0, a_data};
        spfp_pkg::REG_A_DIR: prdata <= {26'h0, a_dir};
        spfp_pkg::REG_B_DATA: prdata <= {24'h0, b_data};
        spfp_pkg::REG_B_DIR: prdata <= {24'h0, b_dir};
        spfp_pkg::REG_A_PINS: prdata <= {26'h0, a_sync};
        spfp_pkg::REG_B_PINS: prdata <= {24'h0, b_sync};
        spfp_pkg::REG_OWNER: prdata <= {14'h0, owner_vec};
        default: prdata <= 32'h0000_0000;
      endcase
      if (addr_bad(paddr)) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  a_reset_inputs: assert property (@(posedge pclk)
    $rose(presetn) |-> port_a_oe == 6'h00 && port_b_lines_oe == 8'h00)
    else $error("pin driven right after reset");
  a_bit2_no_drive: assert property (@(posedge pclk)
    disable iff (!presetn) port_a_oe[2] == 1'b0)
    else $error("port a bit 2 driven");
  a_bit0_analog: assert property (@(posedge pclk)
    disable iff (!presetn)
    func_en[spfp_pkg::FE_AN0] |-> !port_a_oe[0] && analog_chan_sel[0]
    && timer_chan_in[0] == 1'b0)
    else $error("analog 0 does not own bit 0");
  a_bit1_timer: assert property (@(posedge pclk)
    disable iff (!presetn)
    !func_en[spfp_pkg::FE_AN1] && func_en[spfp_pkg::FE_TIM1]
    |-> port_a_oe[1] == timer_chan_oe[1])
    else $error("timer 1 does not drive bit 1");
  a_bit2_irq: assert property (@(posedge pclk)
    disable iff (!presetn)
    func_en[spfp_pkg::FE_IRQ] |-> keypad_irq_in[2] && !timer_ext_clock_in)
    else $error("bit 2 leaked past the interrupt input");
  a_bit3_reset: assert property (@(posedge pclk)
    disable iff (!presetn)
    func_en[spfp_pkg::FE_RST] |-> port_a_pullup[3] && !port_a_oe[3])
    else $error("reset pin lacks pullup");
  a_bit4_osc: assert property (@(posedge pclk)
    disable iff (!presetn)
    oscillator_out_enable |-> port_a_oe[4] && port_a_out[4] == osc_clk
    && !analog_chan_sel[2])
    else $error("oscillator output not on bit 4");
  a_bit5_osc: assert property (@(posedge pclk)
    disable iff (!presetn)
    func_en[spfp_pkg::FE_OSCIN] |-> !analog_chan_sel[3]
    && keypad_irq_in[5])
    else $error("oscillator input not owner of bit 5");
  a_port_dir: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_en && paddr == spfp_pkg::REG_B_DIR |=> port_b_lines_oe
    == (HAS_PORT_B ? $past(pwdata[7:0]) : 8'h00))
    else $error("port b direction not applied");
  c_osc_out: cover property (@(posedge pclk) oscillator_out_enable);
  c_timer0: cover property (@(posedge pclk)
    port_a_oe[0] && func_en[spfp_pkg::FE_TIM0]);
  c_keypad: cover property (@(posedge pclk) owner_vec[2:0] == 3'h3);
endmodule : spfp_pin_mux

/* File: common/spfp_pkg.sv */
// spfp_pkg: register map, field positions and function codes of the pin mux
package spfp_pkg;
  localparam int unsigned NUM_A = 6;
  localparam int unsigned NUM_B = 8;
  // register byte addresses
  localparam logic [7:0] REG_FUNC_EN = 8'h00;
  localparam logic [7:0] REG_KBI_EN = 8'h04;
  localparam logic [7:0] REG_PULLUP = 8'h08;
  localparam logic [7:0] REG_A_DATA = 8'h0C;
  localparam logic [7:0] REG_A_DIR = 8'h10;
  localparam logic [7:0] REG_B_DATA = 8'h14;
  localparam logic [7:0] REG_B_DIR = 8'h18;
  localparam logic [7:0] REG_A_PINS = 8'h1C;
  localparam logic [7:0] REG_B_PINS = 8'h20;
  localparam logic [7:0] REG_OWNER = 8'h24;
  localparam logic [7:0] REG_MAX = 8'h24;
  // function enable bits in REG_FUNC_EN
  localparam int unsigned FE_AN0 = 0;
  localparam int unsigned FE_AN1 = 1;
  localparam int unsigned FE_AN2 = 2;
  localparam int unsigned FE_AN3 = 3;
  localparam int unsigned FE_TIM0 = 4;
  localparam int unsigned FE_TIM1 = 5;
  localparam int unsigned FE_TIM_CLK = 6;
  localparam int unsigned FE_IRQ = 7;
  localparam int unsigned FE_RST = 8;
  localparam int unsigned FE_OSCIN = 9;
  localparam int unsigned FE_W = 10;
  // oscillator-output enable bit inside the pullup register
  localparam int unsigned PU_OSC_OUT = 7;
  localparam int unsigned PU_W = 8;
  // reset values: everything off, every pin a plain input
  localparam logic [FE_W-1:0] FUNC_EN_RST = 10'h000;
  localparam logic [PU_W-1:0] PULLUP_RST = 8'h00;
  // owner codes, 3 bits per pin in REG_OWNER
  typedef enum logic [2:0] {
    SPFP_OWN_PORT = 3'h0,
    SPFP_OWN_ANALOG = 3'h1,
    SPFP_OWN_TIMER = 3'h2,
    SPFP_OWN_KEYPAD = 3'h3,
    SPFP_OWN_IRQ = 3'h4,
    SPFP_OWN_RESET = 3'h5,
    SPFP_OWN_OSC = 3'h6
  } spfp_owner_e;
endpackage : spfp_pkg

/* File: common/spfp_pin_if.sv */
// spfp_pin_if: owner and drive decision of one port a pin
interface spfp_pin_if;
  spfp_pkg::spfp_owner_e owner;
  logic drive;
  logic value;
  modport arb (output owner, output drive, output value);
  modport top (input owner, input drive, input value);
endinterface : spfp_pin_if

/* File: rtl/spfp_arbiter.sv */
// spfp_arbiter: fixed priority selection of the owner of each port a pin
module spfp_arbiter (
  input wire logic [spfp_pkg::FE_W-1:0] func_en,
  input wire logic [5:0] kbi_en,
  input wire logic osc_out_en,
  input wire logic [5:0] a_data,
  input wire logic [5:0] a_dir,
  input wire logic [1:0] tim_out,
  input wire logic [1:0] tim_oe,
  input wire logic osc_clk,
  spfp_pin_if.arb p0,
  spfp_pin_if.arb p1,
  spfp_pin_if.arb p2,
  spfp_pin_if.arb p3,
  spfp_pin_if.arb p4,
  spfp_pin_if.arb p5
);
  // bits 0 and 1: analog, then timer, then keypad, then port
  always_comb begin
    if (func_en[spfp_pkg::FE_AN0]) begin
      p0.owner = spfp_pkg::SPFP_OWN_ANALOG;
      p0.drive = 1'b0;
    end else if (func_en[spfp_pkg::FE_TIM0]) begin
      p0.owner = spfp_pkg::SPFP_OWN_TIMER;
      p0.drive = tim_oe[0];
    end else if (kbi_en[0]) begin
      p0.owner = spfp_pkg::SPFP_OWN_KEYPAD;
      p0.drive = 1'b0;
    end else begin
      p0.owner = spfp_pkg::SPFP_OWN_PORT;
      p0.drive = a_dir[0];
    end
    p0.value = func_en[spfp_pkg::FE_TIM0] ? tim_out[0] : a_data[0];
  end

  always_comb begin
    if (func_en[spfp_pkg::FE_AN1]) begin
      p1.owner = spfp_pkg::SPFP_OWN_ANALOG;
      p1.drive = 1'b0;
    end else if (func_en[spfp_pkg::FE_TIM1]) begin
      p1.owner = spfp_pkg::SPFP_OWN_TIMER;
      p1.drive = tim_oe[1];
    end else if (kbi_en[1]) begin
      p1.owner = spfp_pkg::SPFP_OWN_KEYPAD;
      p1.drive = 1'b0;
    end else begin
      p1.owner = spfp_pkg::SPFP_OWN_PORT;
      p1.drive = a_dir[1];
    end
    p1.value = func_en[spfp_pkg::FE_TIM1] ? tim_out[1] : a_data[1];
  end

  // bit 2 never drives: every function on it is an input
  always_comb begin
    p2.drive = 1'b0;
    p2.value = 1'b0;
    if (func_en[spfp_pkg::FE_IRQ]) begin
      p2.owner = spfp_pkg::SPFP_OWN_IRQ;
    end else if (kbi_en[2]) begin
      p2.owner = spfp_pkg::SPFP_OWN_KEYPAD;
    end else if (func_en[spfp_pkg::FE_TIM_CLK]) begin
      p2.owner = spfp_pkg::SPFP_OWN_TIMER;
    end else begin
      p2.owner = spfp_pkg::SPFP_OWN_PORT;
    end
  end

  always_comb begin
    p3.value = a_data[3];
    if (func_en[spfp_pkg::FE_RST]) begin
      p3.owner = spfp_pkg::SPFP_OWN_RESET;
      p3.drive = 1'b0;
    end else if (kbi_en[3]) begin
      p3.owner = spfp_pkg::SPFP_OWN_KEYPAD;
      p3.drive = 1'b0;
    end else begin
      p3.owner = spfp_pkg::SPFP_OWN_PORT;
      p3.drive = a_dir[3];
    end
  end

  // bit 4: oscillator output drives the clock out
  always_comb begin
    p4.value = a_data[4];
    if (osc_out_en) begin
      p4.owner = spfp_pkg::SPFP_OWN_OSC;
      p4.drive = 1'b1;
      p4.value = osc_clk;
    end else if (func_en[spfp_pkg::FE_AN2]) begin
      p4.owner = spfp_pkg::SPFP_OWN_ANALOG;
      p4.drive = 1'b0;
    end else if (kbi_en[4]) begin
      p4.owner = spfp_pkg::SPFP_OWN_KEYPAD;
      p4.drive = 1'b0;
    end else begin
      p4.owner = spfp_pkg::SPFP_OWN_PORT;
      p4.drive = a_dir[4];
    end
  end

  always_comb begin
    p5.value = a_data[5];
    if (func_en[spfp_pkg::FE_OSCIN]) begin
      p5.owner = spfp_pkg::SPFP_OWN_OSC;
      p5.drive = 1'b0;
    end else if (func_en[spfp_pkg::FE_AN3]) begin
      p5.owner = spfp_pkg::SPFP_OWN_ANALOG;
      p5.drive = 1'b0;
    end else if (kbi_en[5]) begin
      p5.owner = spfp_pkg::SPFP_OWN_KEYPAD;
      p5.drive = 1'b0;
    end else begin
      p5.owner = spfp_pkg::SPFP_OWN_PORT;
      p5.drive = a_dir[5];
    end
  end
endmodule : spfp_arbiter

/* File: tb/spfp_board_model.sv */
// spfp_board_model: board circuitry seen by the shared port pins
module spfp_board_model (
  input wire logic pclk,
  input wire logic [5:0] a_out,
  input wire logic [5:0] a_oe,
  input wire logic [5:0] a_pu,
  input wire logic [5:0] brd_en,
  input wire logic [5:0] brd_val,
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe,
  input wire logic [7:0] b_val,
  output logic [5:0] a_pad,
  output logic [7:0] b_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flt = 1'h0;
  // an undriven line without pullup wanders, so nothing may rely on it
  always @(posedge pclk) flt <= ~flt;
  // pad level: device driver first, then the board, then the pullup
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (a_oe[i])
        a_pad[i] = a_out[i];
      else if (brd_en[i])
        a_pad[i] = brd_val[i];
      else
        a_pad[i] = a_pu[i] | flt;
    end
  end
  // port b lines are always loaded by the board when not driven
  assign b_pad = (b_oe & b_out) | (~b_oe & b_val);
endmodule : spfp_board_model

/* File: tb/testbench.sv */
// testbench: self-checking bench of the shared pin function mux
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
  n_errors++; end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] PT = spfp_pkg::SPFP_OWN_PORT;
  localparam logic [2:0] AN = spfp_pkg::SPFP_OWN_ANALOG;
  localparam logic [2:0] TM = spfp_pkg::SPFP_OWN_TIMER;
  localparam logic [2:0] KP = spfp_pkg::SPFP_OWN_KEYPAD;
  localparam logic [2:0] IQ = spfp_pkg::SPFP_OWN_IRQ;
  localparam logic [2:0] RS = spfp_pkg::SPFP_OWN_RESET;
  localparam logic [2:0] OS = spfp_pkg::SPFP_OWN_OSC;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [5:0] port_a_in, port_a_out, port_a_oe, port_a_pullup;
  logic [7:0] port_b_lines_in, port_b_lines_out, port_b_lines_oe;
  logic [7:0] port_b_pullup;
  logic [1:0] timer_chan_out = 2'h0;
  logic [1:0] timer_chan_oe = 2'h0;
  logic osc_clk = 1'h0;
  logic [1:0] timer_chan_in;
  logic timer_ext_clock_in, ext_irq_n, ext_reset_n, oscillator_in_pin;
  logic [5:0] keypad_irq_in;
  logic [3:0] analog_chan_sel;
  logic [5:0] ben = 6'h3F;
  logic [5:0] bv = 6'h00;
  logic [7:0] bb = 8'h00;
  logic [9:0] fe = 10'h000;
  logic [15:0] pu = 16'h0000;
  logic [5:0] kb = 6'h00, dir = 6'h00, dat = 6'h00, epu = 6'h00;
  logic [7:0] bdir = 8'h00, bdat = 8'h00;
  logic [15:0] lfsr = 16'hA945;
  logic [33:0] ent;
  logic [33:0] expq [$];
  int n_errors = 0;
  int n_checks = 0;

  spfp_pin_mux #(.HAS_PORT_B(1'b1)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_in(port_a_in), .port_a_out(port_a_out),
    .port_a_oe(port_a_oe), .port_a_pullup(port_a_pullup),
    .port_b_lines_in(port_b_lines_in), .port_b_lines_out(port_b_lines_out),
    .port_b_lines_oe(port_b_lines_oe), .port_b_pullup(port_b_pullup),
    .timer_chan_out(timer_chan_out), .timer_chan_oe(timer_chan_oe),
    .osc_clk(osc_clk), .timer_chan_in(timer_chan_in),
    .timer_ext_clock_in(timer_ext_clock_in), .ext_irq_n(ext_irq_n),
    .ext_reset_n(ext_reset_n), .oscillator_in_pin(oscillator_in_pin),
    .keypad_irq_in(keypad_irq_in), .analog_chan_sel(analog_chan_sel));

  spfp_board_model board (.pclk(pclk), .a_out(port_a_out),
    .a_oe(port_a_oe), .a_pu(port_a_pullup), .brd_en(ben), .brd_val(bv),
    .b_out(port_b_lines_out), .b_oe(port_b_lines_oe), .b_val(bb),
    .a_pad(port_a_in), .b_pad(port_b_lines_in));

  // free running clock, 10 ns period
  always #5 pclk = ~pclk;

  // each finished transfer is matched against the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (expq.size() == 0) begin
        `CHK("spare transfer", 1'h0, 1'h1)
      end else begin
        ent = expq.pop_front();
        `CHK("pslverr", ent[32], pslverr)
        if (ent[33]) `CHK("prdata", ent[31:0], prdata)
      end
    end
  end

  // wide steps so that successive draws are not mere shifts
  function automatic logic [15:0] nxt(input logic [15:0] s);
    logic [15:0] r;
    r = s;
    repeat (16) r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    return r;
  endfunction : nxt

  function automatic logic [2:0] pick(input logic a, input logic [2:0] ca,
      input logic b, input logic [2:0] cb, input logic c,
      input logic [2:0] cc);
    return a ? ca : (b ? cb : (c ? cc : PT));
  endfunction : pick

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // one apb transfer; the wait on pready is bounded
  task automatic apb(input logic wr, input logic [7:0] adr,
      input logic [31:0] wd, input logic [31:0] ed, input logic er);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    expq.push_back({~wr, er, ed});
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!pready && k < 50);
    if (!pready) begin
      n_errors++;
      tally_and_finish();
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    apb(1'h1, adr, d, 32'h0, 1'h0);
  endtask : wr

  task automatic rd(input logic [7:0] adr, input logic [31:0] e);
    apb(1'h0, adr, 32'h0, e, 1'h0);
  endtask : rd

  // expected pin state from the current settings, then compare
  task automatic check_pins();
    logic [2:0] own [6];
    logic [5:0] eoe, eout, epad, ekb;
    logic [1:0] etc;
    logic [7:0] bpad;
    repeat (3) @(negedge pclk);
    own[0] = pick(fe[0], AN, fe[4], TM, kb[0], KP);
    own[1] = pick(fe[1], AN, fe[5], TM, kb[1], KP);
    own[2] = pick(fe[7], IQ, kb[2], KP, fe[6], TM);
    own[3] = pick(fe[8], RS, kb[3], KP, 1'h0, PT);
    own[4] = pick(pu[7], OS, fe[2], AN, kb[4], KP);
    own[5] = pick(fe[9], OS, fe[3], AN, kb[5], KP);
    for (int i = 0; i < 6; i++) begin
      eoe[i] = (own[i] == PT) && dir[i] && i != 2;
      eout[i] = dat[i];
      if (own[i] == TM && i < 2) begin
        eoe[i] = timer_chan_oe[i];
        eout[i] = timer_chan_out[i];
      end
      if (own[i] == OS && i == 4) begin
        eoe[i] = 1'h1;
        eout[i] = osc_clk;
      end
      epad[i] = eoe[i] ? eout[i] : (ben[i] ? bv[i] : 1'h1);
      ekb[i] = (own[i] == KP) ? epad[i] : 1'h1;
    end
    etc = {own[1] == TM && epad[1], own[0] == TM && epad[0]};
    bpad = (bdir & bdat) | (~bdir & bb);
    `CHK("a_oe", eoe, port_a_oe)
    `CHK("a_out", eout & eoe, port_a_out & eoe)
    `CHK("a_pullup", epu, port_a_pullup)
    `CHK("keypad", ekb, keypad_irq_in)
    `CHK("irq_n", own[2] == IQ ? epad[2] : 1'h1, ext_irq_n)
    `CHK("rst_n", own[3] == RS ? epad[3] : 1'h1, ext_reset_n)
    `CHK("tim_clk", own[2] == TM && epad[2], timer_ext_clock_in)
    `CHK("osc_in", own[5] == OS && epad[5], oscillator_in_pin)
    `CHK("tch_in", etc, timer_chan_in)
    `CHK("analog", {own[5] == AN, own[4] == AN, own[1] == AN,
      own[0] == AN}, analog_chan_sel)
    `CHK("b_oe", bdir, port_b_lines_oe)
    `CHK("b_out", bdat & bdir, port_b_lines_out & bdir)
    `CHK("b_pullup", pu[15:8], port_b_pullup)
    rd(spfp_pkg::REG_OWNER, {14'h0, own[5], own[4], own[3], own[2],
      own[1], own[0]});
    rd(spfp_pkg::REG_A_PINS, {26'h0, epad});
    rd(spfp_pkg::REG_A_DIR, {26'h0, dir & 6'h3B});
    rd(spfp_pkg::REG_B_PINS, {24'h0, bpad});
    rd(spfp_pkg::REG_FUNC_EN, {22'h0, fe});
    rd(spfp_pkg::REG_KBI_EN, {26'h0, kb});
  endtask : check_pins

  // reset, random function mixes, refused accesses, reset again
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    check_pins();
    for (int it = 0; it < 60; it++) begin
      lfsr = nxt(lfsr);
      fe = lfsr[9:0];
      kb = lfsr[15:10];
      lfsr = nxt(lfsr);
      pu = lfsr;
      lfsr = nxt(lfsr);
      dir = lfsr[5:0];
      dat = lfsr[11:6];
      timer_chan_out <= lfsr[13:12];
      timer_chan_oe <= lfsr[15:14];
      lfsr = nxt(lfsr);
      bdir = lfsr[7:0];
      bdat = lfsr[15:8];
      lfsr = nxt(lfsr);
      epu = pu[5:0] | {2'h0, fe[8], 3'h0};
      bv <= lfsr[5:0];
      bb <= lfsr[13:6];
      osc_clk <= lfsr[14];
      ben <= ~epu | lfsr[15:10];
      wr(spfp_pkg::REG_FUNC_EN, {22'h0, fe});
      wr(spfp_pkg::REG_KBI_EN, {26'h0, kb});
      wr(spfp_pkg::REG_PULLUP, {16'h0, pu});
      wr(spfp_pkg::REG_A_DATA, {26'h0, dat});
      wr(spfp_pkg::REG_A_DIR, {26'h0, dir});
      wr(spfp_pkg::REG_B_DATA, {24'h0, bdat});
      wr(spfp_pkg::REG_B_DIR, {24'h0, bdir});
      check_pins();
    end
    apb(1'h1, 8'h01, 32'h3FF, 32'h0, 1'h1);
    apb(1'h1, 8'h28, 32'h3FF, 32'h0, 1'h1);
    apb(1'h0, 8'h28, 32'h0, 32'h0, 1'h1);
    rd(spfp_pkg::REG_FUNC_EN, {22'h0, fe});
    presetn <= 1'h0;
    ben <= 6'h3F;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    fe = 10'h000;
    kb = 6'h00;
    pu = 16'h0000;
    dir = 6'h00;
    dat = 6'h00;
    bdir = 8'h00;
    bdat = 8'h00;
    epu = 6'h00;
    check_pins();
    tally_and_finish();
  end
endmodule : testbench
